// ### hdl/usu_pkg.sv
// Package for the universal serial unit: control, status and constants.
// Assumes a single system clock and a separate serial link clock.
package usu_pkg;

    localparam int          USU_DATA_W   = 8;
    localparam int          USU_CNT_W    = 4;
    localparam int          USU_SYNC_N   = 2;
    localparam logic [7:0]  USU_DATA_RST = 8'h00;
    localparam logic [3:0]  USU_CNT_RST  = 4'h0;
    localparam logic [3:0]  USU_CNT_MAX  = 4'hF;
    localparam logic [3:0]  USU_CNT_ONE  = 4'h1;
    localparam int          USU_MSB      = USU_DATA_W - 1;
    // Software clock divider, unused: strobes may come every system clock period
    localparam int          USU_SW_DIV   = 4;

    typedef enum logic [1:0] {
        USU_WM_OFF      = 2'h0,
        USU_WM_THREE    = 2'h1,
        USU_WM_TWO      = 2'h2,
        USU_WM_TWO_HOLD = 2'h3
    } usu_wire_mode_t;

    typedef enum logic [2:0] {
        USU_HOLD_IDLE  = 3'h1,
        USU_HOLD_START = 3'h2,
        USU_HOLD_OVF   = 3'h4
    } usu_hold_t;

    typedef struct packed {
        logic           start_ie;
        logic           ovf_ie;
        usu_wire_mode_t wire_mode;
        logic           external_clock_select;
        logic           clock_edge_select;
        logic           software_clock_strobe;
        logic           clock_toggle_strobe;
    } usu_ctrl_t;

    // Writing ones to the flags clears them; count is loaded
    typedef struct packed {
        logic       start_flag;
        logic       counter_overflow_flag;
        logic [3:0] count;
    } usu_status_t;

endpackage

// ### hdl/usu_universal_serial_unit.sv
// Universal serial unit: shift register, edge counter, clock select,
// output latch and two-wire clock hold.
// Assumes control/status strobes come from logic on ref_clk and that
// the serial clock pin also feeds link_clk.
// Summary of operation
// - Eight-bit shift register, direct access, no buffer
// - MSB routed to data-out or SDA pin
// - Output latch changes opposite to sampling edge
// - Serial input always from data input pin
// - Readable, writable 4-bit counter with overflow request
// - Shifter and counter share one clock source with internal clock only; external clock counts separately
// - External clock: counter counts both edges, or toggle strobes with strobe counting
// - Clock from pin, timer match or software
// - Two-wire start condition raises request
// - Hold clock low after start or overflow
// - Three-wire is SPI mode 0/1, no select
// - Master and slave registers form a ring
// - Master toggles clock by port or strobe
// - Edge select picks sampling and shifting edges
// - Sixteen edges overflow and flag byte done
// - Overflow request wakes processor from idle
// - Software strobes allow clock up to fck
// - Writing one clears flag, loads count
// - Toggle strobe toggles pin, advances counter
// - Shift toward MSB, new bit at LSB
// - Data write wins over same-cycle shift
// - Latch open first half-cycle, always internal
`timescale 1ns/1ps

module usu_universal_serial_unit (
    input  wire logic                 ref_clk,
    input  wire logic                 rst,
    input  wire logic                 link_clk,
    input  wire logic                 ctrl_wr,
    input  wire usu_pkg::usu_ctrl_t   ctrl_wdata,
    output usu_pkg::usu_ctrl_t        ctrl_rdata,
    input  wire logic                 data_wr,
    input  wire logic [7:0]           data_wdata,
    output logic [7:0]                data_rdata,
    input  wire logic                 status_wr,
    input  wire usu_pkg::usu_status_t status_wdata,
    output usu_pkg::usu_status_t      status_rdata,
    input  wire logic                 timer_compare_match,
    input  wire logic                 port_clock_toggle,
    input  wire logic                 data_out_enable,
    input  wire logic                 clock_out_enable,
    input  wire logic                 serial_data_in,
    output logic                      serial_data_out,
    output logic                      serial_data_out_oe,
    input  wire logic                 sda_in,
    output logic                      sda_out,
    output logic                      sda_oe,
    output logic                      serial_clock_pin_out,
    output logic                      serial_clock_pin_oe,
    output logic                      start_irq,
    output logic                      overflow_irq,
    output logic                      idle_wake
);

    // Link domain: edge toggles and captured input bits
    logic rise_tgl_q;
    logic fall_tgl_q;
    logic rise_bit_q;
    logic fall_bit_q;

    // Link clock may stop, so its flops clear on rst directly
    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            rise_tgl_q <= 1'b0;
            rise_bit_q <= 1'b0;
        end else begin
            rise_tgl_q <= ~rise_tgl_q;
            rise_bit_q <= serial_data_in;
        end
    end

    always_ff @(negedge link_clk or posedge rst) begin
        if (rst) begin
            fall_tgl_q <= 1'b0;
            fall_bit_q <= 1'b0;
        end else begin
            fall_tgl_q <= ~fall_tgl_q;
            fall_bit_q <= serial_data_in;
        end
    end

    // System domain synchronisers
    logic [1:0] rise_sync_q;
    logic [1:0] fall_sync_q;
    logic [1:0] din_sync_q;
    logic [1:0] sda_sync_q;
    logic       rise_seen_q;
    logic       fall_seen_q;
    logic       sda_prev_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            rise_sync_q <= '0;
            fall_sync_q <= '0;
            din_sync_q  <= '0;
            sda_sync_q  <= '1;
            rise_seen_q <= 1'b0;
            fall_seen_q <= 1'b0;
            sda_prev_q  <= 1'b1;
        end else begin
            rise_sync_q <= {rise_sync_q[0], rise_tgl_q};
            fall_sync_q <= {fall_sync_q[0], fall_tgl_q};
            din_sync_q  <= {din_sync_q[0], serial_data_in};
            sda_sync_q  <= {sda_sync_q[0], sda_in};
            rise_seen_q <= rise_sync_q[1];
            fall_seen_q <= fall_sync_q[1];
            sda_prev_q  <= sda_sync_q[1];
        end
    end

    // Configuration held from control writes
    usu_pkg::usu_ctrl_t ctrl_q;
    logic               cnt_on_tgl_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            ctrl_q       <= '0;
            cnt_on_tgl_q <= 1'b0;
        end else if (ctrl_wr) begin
            ctrl_q       <= ctrl_wdata;
            cnt_on_tgl_q <= ctrl_wdata.software_clock_strobe;
        end
    end

    wire usu_pkg::usu_wire_mode_t wm = ctrl_q.wire_mode;
    wire ext_sel  = ctrl_q.external_clock_select;
    wire edge_sel = ctrl_q.clock_edge_select;
    wire three_w  = (wm == usu_pkg::USU_WM_THREE);
    wire two_w    = (wm == usu_pkg::USU_WM_TWO) ||
                    (wm == usu_pkg::USU_WM_TWO_HOLD);

    // Strobes act in the cycle of the write, never from ctrl_q
    wire sw_clk   = ctrl_wr && ctrl_wdata.software_clock_strobe;
    wire tgl_wr   = ctrl_wr && ctrl_wdata.clock_toggle_strobe;

    // Edge events and line level from the link toggles
    wire ext_rise  = rise_sync_q[1] ^ rise_seen_q;
    wire ext_fall  = fall_sync_q[1] ^ fall_seen_q;
    wire scl_level = rise_sync_q[1] ^ fall_sync_q[1];

    // Source select for shift and count
    wire samp_edge = edge_sel ? ext_fall : ext_rise;
    wire int_shift = edge_sel ? timer_compare_match : sw_clk;
    wire shift_ev  = ext_sel ? samp_edge : int_shift;
    // A write that selects strobe counting also counts its own toggle strobe
    wire cnt_on_tgl = ctrl_wr ? ctrl_wdata.software_clock_strobe : cnt_on_tgl_q;
    wire ext_count = cnt_on_tgl ? tgl_wr : (ext_rise || ext_fall);
    wire count_ev  = ext_sel ? ext_count : shift_ev;
    wire ext_bit   = edge_sel ? fall_bit_q : rise_bit_q;
    wire in_bit    = ext_sel ? ext_bit : din_sync_q[1];

    // Shift register
    logic [7:0] data_q;
    logic [7:0] data_d;

    assign data_d = data_wr  ? data_wdata :
                    shift_ev ? {data_q[usu_pkg::USU_MSB-1:0], in_bit} :
                    data_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            data_q <= usu_pkg::USU_DATA_RST;
        end else begin
            data_q <= data_d;
        end
    end

    // Counter and overflow flag
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       ovf_q;
    logic       start_q;

    wire cnt_wrap = count_ev && (cnt_q == usu_pkg::USU_CNT_MAX);
    wire ovf_clr  = status_wr && status_wdata.counter_overflow_flag;
    wire ovf_set  = cnt_wrap && !status_wr;

    assign cnt_d = status_wr ? status_wdata.count :
                   count_ev  ? 4'(cnt_q + usu_pkg::USU_CNT_ONE) :
                   cnt_q;

    // Start detection: SDA falls while SCL is high
    wire start_det = two_w && scl_level && sda_prev_q && !sda_sync_q[1];
    wire start_clr = status_wr && status_wdata.start_flag;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_q   <= usu_pkg::USU_CNT_RST;
            ovf_q   <= 1'b0;
            start_q <= 1'b0;
        end else begin
            cnt_q   <= cnt_d;
            ovf_q   <= ovf_set || (ovf_q && !ovf_clr);
            start_q <= start_det || (start_q && !start_clr);
        end
    end

    // Output latch
    wire latch_open = !ext_sel || (scl_level == edge_sel);
    logic out_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            out_q <= 1'b0;
        end else if (latch_open) begin
            out_q <= data_q[usu_pkg::USU_MSB];
        end
    end

    // Clock pin level driven by the master
    logic clk_pin_q;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            clk_pin_q <= 1'b0;
        end else if (tgl_wr ^ port_clock_toggle) begin
            clk_pin_q <= ~clk_pin_q;
        end
    end

    // Two-wire clock hold
    usu_pkg::usu_hold_t hold_q;
    usu_pkg::usu_hold_t hold_d;

    wire ovf_hold = (wm == usu_pkg::USU_WM_TWO_HOLD);

    always_comb begin
        hold_d = hold_q;
        unique case (hold_q)
            usu_pkg::USU_HOLD_IDLE: begin
                if (start_q && two_w && !scl_level) begin
                    hold_d = usu_pkg::USU_HOLD_START;
                end else if (ovf_q && ovf_hold && !scl_level) begin
                    hold_d = usu_pkg::USU_HOLD_OVF;
                end
            end
            usu_pkg::USU_HOLD_START: begin
                if (!start_q || !two_w) begin
                    hold_d = usu_pkg::USU_HOLD_IDLE;
                end
            end
            usu_pkg::USU_HOLD_OVF: begin
                if (!ovf_q || !ovf_hold) begin
                    hold_d = usu_pkg::USU_HOLD_IDLE;
                end
            end
            default: begin
                hold_d = usu_pkg::USU_HOLD_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hold_q <= usu_pkg::USU_HOLD_IDLE;
        end else begin
            hold_q <= hold_d;
        end
    end

    wire holding = (hold_q != usu_pkg::USU_HOLD_IDLE);

    // Pins: three-wire push-pull, two-wire open drain
    assign serial_data_out      = out_q;
    assign serial_data_out_oe   = three_w && data_out_enable;
    assign sda_out              = 1'b0;
    assign sda_oe               = two_w && data_out_enable && !out_q;
    assign serial_clock_pin_out = two_w ? 1'b0 : clk_pin_q;
    assign serial_clock_pin_oe  = two_w ? ((clock_out_enable && !clk_pin_q) || holding)
                                        : clock_out_enable;

    // Register views and requests
    assign ctrl_rdata   = ctrl_q;
    assign data_rdata   = data_q;
    assign status_rdata = '{start_flag: start_q, counter_overflow_flag: ovf_q,
                            count: cnt_q};
    assign overflow_irq = ovf_q && ctrl_q.ovf_ie;
    assign start_irq    = start_q && ctrl_q.start_ie;
    assign idle_wake    = overflow_irq;

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_shift;
        shift_ev && !data_wr |=> data_q == {$past(data_q[6:0]), $past(in_bit)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift wrong");

    property p_wr_wins;
        data_wr |=> data_q == $past(data_wdata);
    endproperty
    a_wr_wins: assert property (p_wr_wins) else $error("write lost");

    property p_wrap;
        count_ev && !status_wr && cnt_q == usu_pkg::USU_CNT_MAX
            |=> cnt_q == usu_pkg::USU_CNT_RST && ovf_q;
    endproperty
    a_wrap: assert property (p_wrap) else $error("no wrap");

    property p_sticky;
        ovf_q && !status_wr |=> ovf_q;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");

    property p_clear;
        status_wr && status_wdata.counter_overflow_flag
            |=> !ovf_q && cnt_q == $past(status_wdata.count);
    endproperty
    a_clear: assert property (p_clear) else $error("clear failed");

    property p_both_edges;
        ext_sel && !cnt_on_tgl && (ext_rise || ext_fall) && !status_wr
            |=> cnt_q == 4'($past(cnt_q) + usu_pkg::USU_CNT_ONE);
    endproperty
    a_both_edges: assert property (p_both_edges) else $error("edge miss");

    property p_toggle;
        tgl_wr && !port_clock_toggle |=> clk_pin_q != $past(clk_pin_q);
    endproperty
    a_toggle: assert property (p_toggle) else $error("no toggle");

    property p_latch;
        !latch_open |=> $stable(serial_data_out);
    endproperty
    a_latch: assert property (p_latch) else $error("latch moved");

    property p_hold;
        hold_q == usu_pkg::USU_HOLD_START |-> serial_clock_pin_oe && !serial_clock_pin_out;
    endproperty
    a_hold: assert property (p_hold) else $error("clock not held");

    property p_irq;
        ovf_set ##1 ctrl_q.ovf_ie |-> overflow_irq && idle_wake;
    endproperty
    a_irq: assert property (p_irq) else $error("irq missing");

    property p_sw_shift;
        !ext_sel && !edge_sel && sw_clk && !data_wr && !status_wr
            |=> cnt_q == 4'($past(cnt_q) + usu_pkg::USU_CNT_ONE);
    endproperty
    a_sw_shift: assert property (p_sw_shift) else $error("strobe no count");

    c_byte:  cover property (cnt_wrap && ext_sel);
    c_start: cover property (start_det);
    c_clash: cover property (data_wr && shift_ev);

endmodule

// ### test/usu_remote_spi.sv
// Remote SPI peer in data mode 0: clock source as master, or follower as slave.
// Assumes the bench resolves the clock wire and feeds its level back in.
`timescale 1ns/1ps
module usu_remote_spi #(
    parameter int HIGH_NS = 16,
    parameter int LOW_NS  = 16
) (
    input  wire logic       clk_wire,
    input  wire logic       sel,
    input  wire logic       load,
    input  wire logic [7:0] tx_byte,
    input  wire logic       gen,
    input  wire logic       rx_line,
    output logic            tx_line,
    output logic            clk_drive,
    output logic            clk_oe,
    output logic            frame_done,
    output logic [7:0]      rx_byte
);
    logic [7:0] sr_q;
    logic       out_q;
    initial begin
        clk_drive = 1'h0;
        clk_oe = 1'h0;
        frame_done = 1'h0;
        sr_q = 8'h00;
        out_q = 1'h0;
    end
    // Byte and first bit stand well before the first sampling edge
    always @(posedge load) begin
        sr_q = tx_byte;
        out_q = tx_byte[7];
    end
    always @(posedge clk_wire) begin
        if (sel) begin
            sr_q = {sr_q[6:0], rx_line};
        end
    end
    always @(negedge clk_wire) begin
        if (sel) begin
            out_q = sr_q[7];
        end
    end
    // A released line shows the inverse of the last bit
    assign tx_line = sel ? out_q : ~out_q;
    assign rx_byte = sr_q;
    // Eight pulses; clock idles low and stands still outside the frame
    always @(posedge gen) begin
        frame_done = 1'h0;
        clk_oe = 1'h1;
        repeat (8) begin
            #(LOW_NS) clk_drive = 1'h1;
            #(HIGH_NS) clk_drive = 1'h0;
        end
        #(LOW_NS) clk_oe = 1'h0;
        frame_done = 1'h1;
    end
endmodule

// ### test/tb_usu_universal_serial_unit.sv
// Testbench: internal shift table, flags, SPI ring in both roles, two-wire start hold.
// Assumes the package, the design and the remote peer model are compiled first.
`timescale 1ns/1ps
module tb_usu_universal_serial_unit;
    typedef struct packed {
        logic       tmr;
        logic       din;
        logic [7:0] exp;
    } usu_row_t;
    usu_pkg::usu_ctrl_t   ctrl_wdata, ctrl_rdata, cw;
    usu_pkg::usu_status_t status_wdata, status_rdata;
    logic [7:0]           data_wdata, data_rdata, p_tx, p_rx;
    logic                 ref_clk, rst, ctrl_wr, data_wr, status_wr, timer_compare_match, port_clock_toggle;
    logic                 data_out_enable, clock_out_enable, din_tb, sda_in, scl_tb, p_sel, p_load, p_gen;
    logic                 serial_data_out, serial_data_out_oe, sda_out, sda_oe, serial_clock_pin_out;
    logic                 serial_clock_pin_oe, start_irq, overflow_irq, idle_wake, p_tx_line, p_clk, p_clk_oe, p_done;
    wire logic            link_clk, serial_data_in, miso;
    int                   n_errors, samples_checked;
    usu_row_t             rows [8] = '{'{0, 1, 8'h4B}, '{1, 0, 8'h96}, '{0, 0, 8'h2C}, '{1, 1, 8'h59},
                                       '{0, 1, 8'hB3}, '{0, 1, 8'h67}, '{1, 0, 8'hCE}, '{0, 0, 8'h9C}};

    // Clock wire: device driver, then the peer, else the bench level
    assign link_clk = serial_clock_pin_oe ? serial_clock_pin_out : (p_clk_oe ? p_clk : scl_tb);
    assign serial_data_in = p_sel ? p_tx_line : din_tb;
    assign miso = serial_data_out_oe ? serial_data_out : 1'h1;
    always #2 ref_clk = ~ref_clk;

    usu_universal_serial_unit i_usu_universal_serial_unit (
        .ref_clk, .rst, .link_clk, .ctrl_wr, .ctrl_wdata, .ctrl_rdata, .data_wr, .data_wdata, .data_rdata,
        .status_wr, .status_wdata, .status_rdata, .timer_compare_match, .port_clock_toggle, .data_out_enable,
        .clock_out_enable, .serial_data_in, .serial_data_out, .serial_data_out_oe, .sda_in, .sda_out, .sda_oe,
        .serial_clock_pin_out, .serial_clock_pin_oe, .start_irq, .overflow_irq, .idle_wake);
    // Low phase stretched so the synchronised output latch settles before sampling
    usu_remote_spi #(.HIGH_NS(16), .LOW_NS(48)) i_usu_remote_spi (
        .clk_wire(link_clk), .sel(p_sel), .load(p_load), .tx_byte(p_tx), .gen(p_gen), .rx_line(miso),
        .tx_line(p_tx_line), .clk_drive(p_clk), .clk_oe(p_clk_oe), .frame_done(p_done), .rx_byte(p_rx));

    task automatic tick(int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    function automatic usu_pkg::usu_ctrl_t cv(logic [1:0] wm, logic ext, logic edg, logic sw, logic tc);
        cv = usu_pkg::usu_ctrl_t'({2'h3, wm, ext, edg, sw, tc});
    endfunction
    task automatic wr_ctrl(usu_pkg::usu_ctrl_t v);
        ctrl_wdata = v;
        ctrl_wr = 1'h1;
        tick(1);
        ctrl_wr = 1'h0;
    endtask
    task automatic wr_data(logic [7:0] v);
        data_wdata = v;
        data_wr = 1'h1;
        tick(1);
        data_wr = 1'h0;
    endtask
    task automatic wr_stat(logic sf, logic of, logic [3:0] c);
        status_wdata = usu_pkg::usu_status_t'({sf, of, c});
        status_wr = 1'h1;
        tick(1);
        status_wr = 1'h0;
    endtask
    task automatic summarize();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic tmo(int k);
        if (k >= 500) begin
            n_errors++;
            summarize();
        end
    endtask

    initial begin
        int k;
        {ref_clk, ctrl_wr, data_wr, status_wr, timer_compare_match, port_clock_toggle} = 6'h00;
        {din_tb, scl_tb, p_sel, p_load, p_gen} = 5'h00;
        {rst, sda_in, data_out_enable, clock_out_enable} = 4'hE;
        ctrl_wdata = usu_pkg::usu_ctrl_t'(8'h00);
        status_wdata = usu_pkg::usu_status_t'(6'h00);
        data_wdata = 8'h00;
        p_tx = 8'h00;
        n_errors = 0;
        samples_checked = 0;
        repeat (8) @(posedge ref_clk);
        #1 rst = 1'h0;
        chk("reset", 8'h00, {status_rdata, overflow_irq, start_irq});
        wr_data(8'hA5);
        wr_stat(1'h0, 1'h1, 4'h0);
        foreach (rows[i]) begin
            din_tb = rows[i].din;
            wr_ctrl(cv(2'h1, 1'h0, rows[i].tmr, 1'h0, 1'h0));
            tick(2);
            if (rows[i].tmr) begin
                timer_compare_match = 1'h1;
                tick(1);
                timer_compare_match = 1'h0;
            end else begin
                wr_ctrl(cv(2'h1, 1'h0, 1'h0, 1'h1, 1'h0));
            end
            tick(3);
            chk("data", rows[i].exp, data_rdata);
            chk("count", 8'(i + 1), 8'(status_rdata.count));
            chk("data_out", 8'(rows[i].exp[7]), 8'(serial_data_out));
        end
        wr_stat(1'h0, 1'h0, 4'hF);
        wr_ctrl(cv(2'h1, 1'h0, 1'h0, 1'h1, 1'h0));
        tick(2);
        chk("wrap", 8'h10, 8'(status_rdata));
        chk("irq_wake", 8'h03, 8'({overflow_irq, idle_wake}));
        cw = cv(2'h1, 1'h0, 1'h0, 1'h0, 1'h0);
        cw.ovf_ie = 1'h0;
        wr_ctrl(cw);
        tick(1);
        chk("masked_irq", 8'h00, 8'(overflow_irq));
        chk("ctrl_rd", cw, ctrl_rdata);
        wr_stat(1'h0, 1'h0, 4'h3);
        tick(1);
        chk("sticky", 8'h13, 8'(status_rdata));
        wr_stat(1'h0, 1'h1, 4'h5);
        tick(1);
        chk("cleared", 8'h05, 8'(status_rdata));
        ctrl_wdata = cv(2'h1, 1'h0, 1'h0, 1'h1, 1'h0);
        ctrl_wr = 1'h1;
        tick(2);
        ctrl_wr = 1'h0;
        tick(1);
        chk("fast_cnt", 8'h07, 8'(status_rdata.count));
        data_wdata = 8'h5A;
        ctrl_wdata = cv(2'h1, 1'h0, 1'h0, 1'h1, 1'h0);
        {data_wr, ctrl_wr} = 2'h3;
        tick(1);
        {data_wr, ctrl_wr} = 2'h0;
        tick(3);
        chk("write_wins", 8'h5A, data_rdata);
        chk("dout_pin", 8'h02, 8'({serial_data_out_oe, serial_data_out}));
        p_sel = 1'h1;
        wr_ctrl(cv(2'h1, 1'h1, 1'h0, 1'h0, 1'h0));
        wr_data(8'h3C);
        wr_stat(1'h0, 1'h1, 4'h0);
        p_tx = 8'hD2;
        p_load = 1'h1;
        #7 p_gen = 1'h1;
        tick(1);
        {p_load, p_gen} = 2'h0;
        for (k = 0; k < 500 && p_done !== 1'h1; k++) tick(1);
        tmo(k);
        tick(8);
        chk("slave_rx", 8'hD2, data_rdata);
        chk("peer_rx", 8'h3C, p_rx);
        chk("slave_stat", 8'h10, 8'(status_rdata));
        wr_data(8'hE7);
        wr_stat(1'h0, 1'h1, 4'h0);
        p_tx = 8'h19;
        p_load = 1'h1;
        tick(1);
        p_load = 1'h0;
        clock_out_enable = 1'h1;
        for (k = 0; k < 16; k++) begin
            wr_ctrl(cv(2'h1, 1'h1, 1'h0, 1'h1, 1'h1));
            tick(7);
            if (k == 0) chk("pin_cnt", 8'h11, 8'({serial_clock_pin_out, status_rdata.count}));
        end
        chk("master_rx", 8'h19, data_rdata);
        chk("peer_rx2", 8'hE7, p_rx);
        chk("master_stat", 8'h10, 8'(status_rdata));
        wr_ctrl(cv(2'h1, 1'h0, 1'h0, 1'h0, 1'h0));
        port_clock_toggle = 1'h1;
        tick(1);
        port_clock_toggle = 1'h0;
        tick(2);
        chk("port_pin", 8'h01, 8'(serial_clock_pin_out));
        {rst, p_sel} = 2'h2;
        tick(2);
        rst = 1'h0;
        chk("reset2", 8'h00, {status_rdata, overflow_irq, start_irq});
        scl_tb = 1'h1;
        wr_ctrl(cv(2'h2, 1'h1, 1'h0, 1'h0, 1'h0));
        port_clock_toggle = 1'h1;
        tick(1);
        port_clock_toggle = 1'h0;
        tick(4);
        chk("sda_pin", 8'h02, 8'({sda_out, sda_oe, serial_data_out_oe}));
        sda_in = 1'h0;
        tick(6);
        chk("start", 8'h03, 8'({status_rdata.start_flag, start_irq}));
        scl_tb = 1'h0;
        for (k = 0; k < 500 && serial_clock_pin_oe !== 1'h1; k++) tick(1);
        tmo(k);
        chk("hold", 8'h02, 8'({serial_clock_pin_oe, serial_clock_pin_out}));
        wr_stat(1'h1, 1'h0, 4'h0);
        tick(6);
        chk("release", 8'h00, 8'({serial_clock_pin_oe, start_irq}));
        summarize();
    end
endmodule
